// File: shared/tdmcm_pkg.sv
// Constants and types of the connection-memory block.
// Assumes one clock for both ends.
package tdmcm_pkg;
  // Connection memory shape
  localparam int CM_DEPTH = 512;
  localparam int CM_W     = 12;
  // Device word addresses
  localparam logic [11:0] A_CM_LAST = 12'h01FF;
  localparam logic [11:0] A_CTRL    = 12'h0200;
  localparam logic [11:0] A_MODE    = 12'h0201;
  localparam logic [11:0] A_IDLY    = 12'h0210; // 16 input delay registers
  localparam logic [11:0] A_ODLY    = 12'h0220; // 16 output offset registers
  // Field positions
  localparam int CM_SEL     = 0;
  localparam int CM_CH_LO   = 1;
  localparam int CM_ST_LO   = 8;
  localparam int CM_MSG_LO  = 3;
  localparam int CTRL_EN    = 0;
  localparam int CTRL_RATE  = 1;  // 2 bits: 0=32, 1=64, 2=128 channels
  localparam int MODE_START = 0;
  localparam int MODE_PAT   = 1;  // 3 pattern bits
  localparam int IDLY_CD    = 3;  // 7-bit input channel delay
  localparam int ODLY_CD    = 5;  // 7-bit output channel delay
  // Reset values
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [11:0] CM_RST  = 12'h000;
  // Throughput delay bases, in frames
  localparam logic [1:0] T_BASE_PLAIN = 2'h2;
  localparam logic [1:0] T_BASE_IDLY  = 2'h3;
  localparam logic [7:0] CHANS_MIN    = 8'h20;
  // Host byte offsets
  localparam logic [4:0] H_JOB   = 5'h00;
  localparam logic [4:0] H_ACC   = 5'h04;
  localparam logic [4:0] H_WDATA = 5'h08;
  localparam logic [4:0] H_RDATA = 5'h0C;
  localparam logic [4:0] H_STAT  = 5'h10;
  localparam int HACC_READ = 16;
  // Device fill states
  typedef enum logic [1:0] {FS_IDLE = 2'b01, FS_RUN = 2'b10} tdmcm_fstate_t;
  // Per-slot output modes
  typedef enum logic [1:0] {OM_SWITCH, OM_HIZ, OM_MSG, OM_BER} tdmcm_omode_t;
  // Host port phases
  typedef enum logic [2:0] {HP_IDLE = 3'b001, HP_STROBE = 3'b010, HP_RELEASE = 3'b100} tdmcm_hphase_t;
  typedef enum logic [1:0] {J_NONE, J_ACC, J_FILL, J_ABORT} tdmcm_job_t;
  localparam logic [2:0] FILL_POLL = 3'h3;
  localparam logic [2:0] FILL_LAST = 3'h4;
  localparam logic [2:0] ABORT_LAST = 3'h1;
endpackage : tdmcm_pkg

// File: shared/tdmcm_if.sv
// Parallel port between controller and device.
// Assumes one clock; data bus split into two driven halves.
`timescale 1ns/1ns
interface tdmcm_if;
  logic        cs;        // Select
  logic        ds;        // Data strobe
  logic        rw;        // 1 = read
  logic [11:0] addr;
  logic [15:0] d_host;    // Host write data
  logic        d_host_oe;
  logic [15:0] d_dev;     // Device read data
  logic        d_dev_oe;
  logic        dta;       // Access acknowledge
  modport host (output cs, ds, rw, addr, d_host, d_host_oe, input d_dev, d_dev_oe, dta);
  modport dev  (input cs, ds, rw, addr, d_host, d_host_oe, output d_dev, d_dev_oe, dta);
endinterface : tdmcm_if

// File: design/tdmcm_dev.sv
// Device end: connection memory, block fill and throughput delay lookup.
// Assumes host strobes on the same clock.
//
// What this block does
// - Nonzero channel delay adds buffering
// - Bit delays leave throughput unchanged
// - No delays: two frames plus n-m
// - Input delay: three frames minus alpha
// - Output delay: two frames plus beta
// - Both: three frames minus alpha plus beta
// - Channels and delays bounded by rate
// - 512 twelve-bit entries, one per slot
// - Bit0 low: source stream and channel
// - Bit0 high: bits 1-2 pick mode
// - Message mode sends bits 3-10
// - Fill copies pattern, clears the rest
// - Host writes pattern, enable, then start
// - Fill ends within fifty microseconds
// - Start self-clears when fill ends unless the host writes mode that cycle
// - Host clears enable after that
// - Clearing start or enable aborts fill
// - Enable abort: host clears start
// - Port moves entries; upper bits zero
// - Input channel delay in bits 3-9
// - Output channel delay in bits 5-11
`timescale 1ns/1ns
module tdmcm_dev (
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  // Host port
  tdmcm_if.dev                        port_if,
  // Switching lookup
  input  wire logic [8:0]             slot_in,
  output logic [3:0]                  src_stream_out,
  output logic [6:0]                  src_chan_out,
  output tdmcm_pkg::tdmcm_omode_t     slot_mode_out,
  output logic [7:0]                  msg_out,
  output logic [10:0]                 delay_out,
  output logic                        extra_buf_out,
  output logic                        fill_busy_out
);
  import tdmcm_pkg::*;

  typedef struct packed {
    logic [CM_DEPTH-1:0][CM_W-1:0] cm;
    logic [15:0]                   ctrl;
    logic [15:0]                   mode;
    logic [15:0][15:0]             idly;
    logic [15:0][15:0]             odly;
    tdmcm_fstate_t                 fsm;
    logic [8:0]                    fill_idx;
    logic                          ack;
    logic [15:0]                   rdata;
    logic                          d_oe;
    logic [3:0]                    src_st;
    logic [6:0]                    src_ch;
    tdmcm_omode_t                  om;
    logic [7:0]                    msg;
    logic [10:0]                   dly;
    logic                          xbuf;
  } tdmcm_dev_t;

  tdmcm_dev_t state_reg;
  tdmcm_dev_t state_next;

  // Delay field masked to the rate's top channel
  function automatic logic [6:0] clip_delay(input logic [6:0] d, input logic [1:0] rate);
    logic [6:0] mask;
    mask = (rate == 2'h0) ? 7'h1F : (rate == 2'h1) ? 7'h3F : 7'h7F;
    clip_delay = d & mask;
  endfunction : clip_delay

  // Combinational lookup temporaries
  logic [11:0] ent;
  logic [1:0]  rate;
  logic [6:0]  alpha;
  logic [6:0]  beta;
  logic [7:0]  chans;
  logic [1:0]  base;
  logic [11:0] t_sum;
  logic        acc;

  always_comb begin
    state_next = state_reg;
    rate  = state_reg.ctrl[CTRL_RATE +: 2];
    ent   = state_reg.cm[slot_in];
    acc   = port_if.cs & port_if.ds & ~state_reg.ack;
    alpha = 7'h00;
    beta  = 7'h00;
    chans = CHANS_MIN << rate;
    base  = T_BASE_PLAIN;
    t_sum = 12'h000;

    // Acknowledge stands until strobe drops
    if (!port_if.ds) begin
      state_next.ack  = 1'b0;
      state_next.d_oe = 1'b0;
    end
    if (acc) begin
      state_next.ack   = 1'b1;
      state_next.d_oe  = port_if.rw;
      state_next.rdata = 16'h0000;
      if (port_if.rw) begin
        // Unmapped reads zero; entry upper bits zero
        if (port_if.addr <= A_CM_LAST)
          state_next.rdata = {4'h0, state_reg.cm[port_if.addr[8:0]]};
        else if (port_if.addr == A_CTRL)
          state_next.rdata = state_reg.ctrl;
        else if (port_if.addr == A_MODE)
          state_next.rdata = state_reg.mode;
        else if (port_if.addr[11:4] == A_IDLY[11:4])
          state_next.rdata = state_reg.idly[port_if.addr[3:0]];
        else if (port_if.addr[11:4] == A_ODLY[11:4])
          state_next.rdata = state_reg.odly[port_if.addr[3:0]];
      end else begin
        // Fill wins over entry writes; no interleaving
        if (port_if.addr <= A_CM_LAST && state_reg.fsm != FS_RUN)
          state_next.cm[port_if.addr[8:0]] = port_if.d_host[CM_W-1:0];
        else if (port_if.addr == A_CTRL)
          state_next.ctrl = port_if.d_host;
        else if (port_if.addr == A_MODE)
          state_next.mode = port_if.d_host;
        else if (port_if.addr[11:4] == A_IDLY[11:4])
          state_next.idly[port_if.addr[3:0]] = port_if.d_host;
        else if (port_if.addr[11:4] == A_ODLY[11:4])
          state_next.odly[port_if.addr[3:0]] = port_if.d_host;
      end
    end

    // Block fill: one entry per clock, 512 clocks in all
    case (state_reg.fsm)
      FS_IDLE: begin
        state_next.fill_idx = 9'h000;
        if (state_next.ctrl[CTRL_EN] && state_next.mode[MODE_START])
          state_next.fsm = FS_RUN;
      end
      FS_RUN: begin
        if (!state_next.ctrl[CTRL_EN] || !state_next.mode[MODE_START]) begin
          state_next.fsm = FS_IDLE;
        end else begin
          state_next.cm[state_reg.fill_idx] = {9'h000, state_reg.mode[MODE_PAT +: 3]};
          state_next.fill_idx = state_reg.fill_idx + 9'h001;
          if (state_reg.fill_idx == 9'(CM_DEPTH - 1)) begin
            // A host mode write this cycle wins
            if (!(acc && !port_if.rw && port_if.addr == A_MODE))
              state_next.mode[MODE_START] = 1'b0;
            state_next.fsm = FS_IDLE;
          end
        end
      end
      default: state_next.fsm = FS_IDLE;
    endcase

    // Slot lookup: source, mode, message and throughput delay
    state_next.src_st = ent[CM_ST_LO +: 4];
    state_next.src_ch = ent[CM_CH_LO +: 7];
    state_next.msg    = ent[CM_MSG_LO +: 8];
    if (!ent[CM_SEL])
      state_next.om = OM_SWITCH;
    else
      case (ent[2:1])
        2'h0:    state_next.om = OM_HIZ;
        2'h1:    state_next.om = OM_MSG;
        default: state_next.om = OM_BER;
      endcase
    // Bit and fractional fields never enter the sum
    alpha = clip_delay(state_reg.idly[ent[CM_ST_LO +: 4]][IDLY_CD +: 7], rate);
    beta  = clip_delay(state_reg.odly[slot_in[8:5]][ODLY_CD +: 7], rate);
    if (alpha != 7'h00)
      base = T_BASE_IDLY;
    t_sum = 12'(base * chans) + {5'h00, beta} + {7'h00, slot_in[4:0]}
            - {5'h00, alpha} - {5'h00, clip_delay(ent[CM_CH_LO +: 7], rate)};
    state_next.dly  = t_sum[10:0];
    state_next.xbuf = (alpha != 7'h00) || (beta != 7'h00);
  end

  // State register; memory entries clear on reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg          <= '0;
      state_reg.cm       <= {CM_DEPTH{CM_RST}};
      state_reg.ctrl     <= REG_RST;
      state_reg.mode     <= REG_RST;
      state_reg.fsm      <= FS_IDLE;
      state_reg.om       <= OM_SWITCH;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from state
  assign port_if.d_dev    = state_reg.rdata;
  assign port_if.d_dev_oe = state_reg.d_oe;
  assign port_if.dta      = state_reg.ack;
  assign src_stream_out   = state_reg.src_st;
  assign src_chan_out     = state_reg.src_ch;
  assign slot_mode_out    = state_reg.om;
  assign msg_out          = state_reg.msg;
  assign delay_out        = state_reg.dly;
  assign extra_buf_out    = state_reg.xbuf;
  assign fill_busy_out    = state_reg.fsm == FS_RUN;
endmodule : tdmcm_dev

// File: design/tdmcm_host.sv
// Host end: AXI4-Lite slave that runs single port accesses and fill jobs.
// Assumes the device acknowledges each strobe on the same clock.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
module tdmcm_host (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Device port
  tdmcm_if.host            port_if,
  // AXI4-Lite write
  input  wire logic [4:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  // AXI4-Lite read
  input  wire logic [4:0]  araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in
);
  import tdmcm_pkg::*;

  typedef struct packed {
    logic          aw_h, w_h, awr, wr, bv, arr, rv;
    logic [4:0]    awa;
    logic [31:0]   wd, rd;
    logic [1:0]    br, rr;
    tdmcm_job_t    job;
    logic [2:0]    step;
    tdmcm_hphase_t ph;
    logic [2:0]    pat;
    logic [1:0]    rate;
    logic [12:0]   acc;   // Read flag and address
    logic [15:0]   wdat, rdat;
    logic          cs, ds, rw, oe;
    logic [11:0]   addr;
    logic [15:0]   dout;
  } tdmcm_host_t;

  tdmcm_host_t state_reg;
  tdmcm_host_t state_next;

  // Port operation of a job step: {read, address, data}
  function automatic logic [28:0] step_op(input tdmcm_host_t s);
    logic [15:0] m0, c0;
    m0 = {12'h000, s.pat, 1'b0};
    c0 = {13'h0000, s.rate, 1'b0};
    step_op = {1'b0, A_CTRL, c0};
    case (s.job)
      J_FILL:
        case (s.step)
          3'h0:    step_op = {1'b0, A_MODE, m0};
          3'h1:    step_op = {1'b0, A_CTRL, c0 | 16'h0001};
          3'h2:    step_op = {1'b0, A_MODE, m0 | 16'h0001};
          3'h3:    step_op = {1'b1, A_MODE, 16'h0000};
          default: step_op = {1'b0, A_CTRL, c0};
        endcase
      J_ABORT: step_op = (s.step == 3'h0) ? {1'b0, A_CTRL, c0} : {1'b0, A_MODE, m0};
      J_ACC:   step_op = {s.acc[12], s.acc[11:0],
                          (s.acc[11:0] <= A_CM_LAST) ? {4'h0, s.wdat[11:0]} : s.wdat};
      default: step_op = {1'b0, A_CTRL, c0};
    endcase
  endfunction : step_op

  logic [28:0] op;
  logic        last;

  always_comb begin
    state_next = state_reg;
    op   = step_op(state_reg);
    last = (state_reg.job == J_ACC) || (state_reg.job == J_FILL && state_reg.step == FILL_LAST)
           || (state_reg.job == J_ABORT && state_reg.step == ABORT_LAST);

    // Write channel: address and data taken in either order
    if (awvalid_in && state_reg.awr) begin
      state_next.aw_h = 1'b1;
      state_next.awa  = awaddr_in;
    end
    if (wvalid_in && state_reg.wr) begin
      state_next.w_h = 1'b1;
      state_next.wd  = wdata_in;
    end
    if (state_reg.bv && bready_in)
      state_next.bv = 1'b0;
    if (state_reg.aw_h && state_reg.w_h && !state_reg.bv) begin
      state_next.aw_h = 1'b0;
      state_next.w_h  = 1'b0;
      state_next.bv   = 1'b1;
      state_next.br   = 2'b00;
      case ({state_reg.awa[4:2], 2'b00})
        H_JOB: if (state_reg.job == J_NONE) begin
          state_next.pat  = state_reg.wd[4:2];
          state_next.rate = state_reg.wd[6:5];
          state_next.step = 3'h0;
          if (state_reg.wd[1])
            state_next.job = J_ABORT;
          else if (state_reg.wd[0])
            state_next.job = J_FILL;
        end
        H_ACC: if (state_reg.job == J_NONE) begin
          state_next.acc  = {state_reg.wd[HACC_READ], state_reg.wd[11:0]};
          state_next.step = 3'h0;
          state_next.job  = J_ACC;
        end
        H_WDATA: state_next.wdat = state_reg.wd[15:0];
        H_RDATA, H_STAT: ;
        default: state_next.br = 2'b10;
      endcase
    end
    state_next.awr = !state_next.aw_h;
    state_next.wr  = !state_next.w_h;

    // Read channel
    if (state_reg.rv && rready_in)
      state_next.rv = 1'b0;
    if (arvalid_in && state_reg.arr) begin
      state_next.rv = 1'b1;
      state_next.rr = 2'b00;
      case ({araddr_in[4:2], 2'b00})
        H_JOB:   state_next.rd = {25'h0000_000, state_reg.rate, state_reg.pat, 2'b00};
        H_ACC:   state_next.rd = {15'h0000, state_reg.acc[12], 4'h0, state_reg.acc[11:0]};
        H_WDATA: state_next.rd = {16'h0000, state_reg.wdat};
        H_RDATA: state_next.rd = {16'h0000, state_reg.rdat};
        H_STAT:  state_next.rd = {30'h0000_0000, state_reg.job};
        default: begin
          state_next.rd = 32'h0000_0000;
          state_next.rr = 2'b10;
        end
      endcase
    end
    state_next.arr = !state_next.rv;

    // Port sequencer: strobe, wait acknowledge, release, wait release
    case (state_reg.ph)
      HP_IDLE: if (state_reg.job != J_NONE) begin
        state_next.cs   = 1'b1;
        state_next.ds   = 1'b1;
        state_next.rw   = op[28];
        state_next.addr = op[27:16];
        state_next.dout = op[15:0];
        state_next.oe   = !op[28];
        state_next.ph   = HP_STROBE;
      end
      HP_STROBE: if (port_if.dta) begin
        if (state_reg.rw)
          state_next.rdat = port_if.d_dev;
        state_next.cs = 1'b0;
        state_next.ds = 1'b0;
        state_next.oe = 1'b0;
        state_next.ph = HP_RELEASE;
      end
      HP_RELEASE: if (!port_if.dta) begin
        state_next.ph = HP_IDLE;
        // Poll until start self-clears
        if (state_reg.job == J_FILL && state_reg.step == FILL_POLL && state_reg.rdat[MODE_START])
          state_next.step = FILL_POLL;
        else if (last)
          state_next.job = J_NONE;
        else
          state_next.step = state_reg.step + 3'h1;
      end
      default: state_next.ph = HP_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg     <= '0;
      state_reg.awr <= 1'b1;
      state_reg.wr  <= 1'b1;
      state_reg.arr <= 1'b1;
      state_reg.job <= J_NONE;
      state_reg.ph  <= HP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from state
  assign awready_out       = state_reg.awr;
  assign wready_out        = state_reg.wr;
  assign bvalid_out        = state_reg.bv;
  assign bresp_out         = state_reg.br;
  assign arready_out       = state_reg.arr;
  assign rvalid_out        = state_reg.rv;
  assign rdata_out         = state_reg.rd;
  assign rresp_out         = state_reg.rr;
  assign port_if.cs        = state_reg.cs;
  assign port_if.ds        = state_reg.ds;
  assign port_if.rw        = state_reg.rw;
  assign port_if.addr      = state_reg.addr;
  assign port_if.d_host    = state_reg.dout;
  assign port_if.d_host_oe = state_reg.oe;
endmodule : tdmcm_host

// File: testbench/tdmcm_monitor.sv
// Checker for the host port between controller and device.
// Assumes one clock; the bench wires in the interface signals.
`timescale 1ns/1ns
module tdmcm_monitor (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  // Port signals
  input wire logic        cs,
  input wire logic        ds,
  input wire logic        rw,
  input wire logic [11:0] addr,
  input wire logic [15:0] d_host,
  input wire logic        d_host_oe,
  input wire logic [15:0] d_dev,
  input wire logic        d_dev_oe,
  input wire logic        dta
);
  import tdmcm_pkg::*;
  // Fill budget of 50 us at 10 ns a cycle
  localparam logic [12:0] FILL_MAX = 13'h1388;
  logic        en_reg;
  logic [2:0]  pat_reg;
  logic        fill_on_reg;
  logic [12:0] cnt_reg;
  logic        wr_take;
  logic        rd_done;
  // Write taken where strobe meets low acknowledge
  assign wr_take = cs && ds && !dta && !rw;
  assign rd_done = cs && dta && rw && d_dev_oe && addr == A_MODE && !d_dev[MODE_START];
  // Shadow enable and pattern; time a fill until seen ended or stopped
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_reg      <= 1'b0;
      pat_reg     <= 3'h0;
      fill_on_reg <= 1'b0;
      cnt_reg     <= 13'h0000;
    end else begin
      cnt_reg <= fill_on_reg ? cnt_reg + 13'h0001 : 13'h0000;
      if (wr_take && addr == A_CTRL) begin
        en_reg <= d_host[CTRL_EN];
      end
      if (wr_take && addr == A_MODE) begin
        pat_reg     <= d_host[3:1];
        fill_on_reg <= d_host[MODE_START] && en_reg;
      end else if (rd_done || (wr_take && addr == A_CTRL && !d_host[CTRL_EN])) begin
        fill_on_reg <= 1'b0;
      end
    end
  end
  // One domain: one clocking, one disable
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  property p_ack_next;
    cs && ds && !dta |=> dta;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("No acknowledge");
  property p_req_hold;
    cs && ds && !dta |=> cs && ds && $stable(addr) && $stable(rw) && $stable(d_host);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("Request moved");
  property p_ack_stand;
    dta && ds |=> dta;
  endproperty
  a_ack_stand: assert property (p_ack_stand) else $error("Acknowledge dropped");
  property p_ack_release;
    dta && !ds |=> !dta && !d_dev_oe;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("Acknowledge held");
  property p_rd_upper;
    cs && dta && rw && d_dev_oe && addr <= A_CM_LAST |-> d_dev[15:12] == 4'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("Read upper bits");
  property p_wr_upper;
    wr_take && addr <= A_CM_LAST |-> d_host_oe && d_host[15:12] == 4'h0;
  endproperty
  a_wr_upper: assert property (p_wr_upper) else $error("Write upper bits");
  property p_no_clash;
    !(d_host_oe && d_dev_oe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("Bus clash");
  property p_pat_first;
    wr_take && addr == A_MODE && d_host[MODE_START] && en_reg |-> d_host[3:1] == pat_reg;
  endproperty
  a_pat_first: assert property (p_pat_first) else $error("Start before pattern");
  property p_fill_bound;
    fill_on_reg |-> cnt_reg < FILL_MAX;
  endproperty
  a_fill_bound: assert property (p_fill_bound) else $error("Fill too long");
endmodule : tdmcm_monitor

// File: testbench/tdm_connection_memory_delay_tb_top.sv
// Bench: controller and device joined by the port.
// Assumes the package's host and device maps.
`timescale 1ns/1ns
module tdm_connection_memory_delay_tb_top;
  import tdmcm_pkg::*;
  // Bench signals
  logic         clk_in, rst_n_in, awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, extra_buf, fill_busy;
  logic [8:0]   slot;
  logic [4:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata;
  logic [1:0]   bresp, rresp;
  logic [3:0]   src_stream;
  logic [6:0]   src_chan;
  tdmcm_omode_t slot_mode;
  logic [7:0]   msg;
  logic [10:0]  dly;
  int           n_fail, checked, seed, busy_n, rate, cm[512], idly[16], odly[16];
  int           rst_a[7] = '{0, A_CM_LAST, A_CTRL, A_MODE, A_IDLY, A_ODLY + 15, 12'h0300};
  int           probe[3] = '{0, 12'h0155, A_CM_LAST};
  tdmcm_if tdmcm_if_i ();
  tdmcm_dev tdmcm_dev_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .port_if(tdmcm_if_i), .slot_in(slot),
    .src_stream_out(src_stream), .src_chan_out(src_chan), .slot_mode_out(slot_mode), .msg_out(msg),
    .delay_out(dly), .extra_buf_out(extra_buf), .fill_busy_out(fill_busy));
  tdmcm_host tdmcm_host_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .port_if(tdmcm_if_i), .awaddr_in(awaddr),
    .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata), .wvalid_in(wvalid), .wready_out(wready),
    .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready));
  tdmcm_monitor tdmcm_monitor_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .cs(tdmcm_if_i.cs), .ds(tdmcm_if_i.ds),
    .rw(tdmcm_if_i.rw), .addr(tdmcm_if_i.addr), .d_host(tdmcm_if_i.d_host), .d_host_oe(tdmcm_if_i.d_host_oe),
    .d_dev(tdmcm_if_i.d_dev), .d_dev_oe(tdmcm_if_i.d_dev_oe), .dta(tdmcm_if_i.dta));
  // 100 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Count fill cycles for the budget check
  always @(posedge clk_in) if (fill_busy === 1'b1) busy_n++;
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // Each channel holds until its own ready
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask : axi_rd
  // Poll until no job; the watchdog bounds a hang
  task automatic wait_idle();
    logic [31:0] s;
    logic [1:0]  r;
    do axi_rd(H_STAT, s, r); while (s[1:0] !== 2'h0);
  endtask : wait_idle
  task automatic dev_wr(input int a, input int d);
    logic [1:0] r;
    axi_wr(H_WDATA, d, r);
    axi_wr(H_ACC, a, r);
    wait_idle();
    if (a < 512) cm[a] = d;
    else if (a >= A_IDLY && a < A_ODLY) idly[a - A_IDLY] = d;
    else if (a >= A_ODLY && a < A_ODLY + 16) odly[a - A_ODLY] = d;
  endtask : dev_wr
  task automatic dev_rd(input int a, output logic [31:0] d);
    logic [1:0] r;
    axi_wr(H_ACC, 32'h0001_0000 | a, r);
    wait_idle();
    axi_rd(H_RDATA, d, r);
  endtask : dev_rd
  // Check one slot's lookup against the model
  task automatic look(input int s);
    int e, mk, al, be, m;
    e = cm[s];
    mk = (32 << rate) - 1;
    al = (idly[(e >> 8) & 15] >> 3) & mk;
    be = (odly[s >> 5] >> 5) & mk;
    m = (e >> 1) & mk;
    @(posedge clk_in);
    slot <= s[8:0];
    @(posedge clk_in);
    #1;
    if (e % 2 == 0) begin
      chk("mode", slot_mode, OM_SWITCH);
      chk("src", {src_stream, src_chan}, e >> 1);
      chk("delay", dly, ((al != 0 ? 3 : 2) * (mk + 1) + be + (s & 31) - al - m) & 16'h07FF);
      chk("xbuf", extra_buf, al != 0 || be != 0);
    end else begin
      chk("mode", slot_mode, (e & 4) ? OM_BER : (e & 2) ? OM_MSG : OM_HIZ);
      if ((e & 6) == 2) chk("msg", msg, (e >> 3) & 255);
    end
  endtask : look
  // Limit well above the run of some 7k cycles
  initial begin
    #900000;
    n_fail++;
    give_verdict();
  end
  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    int          s, os, a, mk, p;
    {rst_n_in, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, slot} = '0;
    {n_fail, checked, busy_n, rate} = '0;
    seed = 76191;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // Reset values and unmapped places
    axi_rd(H_STAT, v, r);
    chk("stat", v, 0);
    axi_rd(5'h14, v, r);
    chk("unmapped read", {r, v}, {2'h2, 32'h0});
    axi_wr(5'h18, 1, r);
    chk("unmapped write", r, 2);
    foreach (rst_a[i]) begin
      dev_rd(rst_a[i], v);
      chk("reset", v, 0);
    end
    // Entry write and read back, both ends
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 0 : (i == 1) ? 511 : {$random(seed)} % 512;
      dev_wr(a, $random(seed) & 12'hFFF);
      dev_rd(a, v);
      chk("entry", v, cm[a]);
    end
    // Per rate: four delay cases, then the four mode codes of bits 1-2
    for (int rt = 0; rt < 3; rt++) begin
      rate = rt;
      mk = (32 << rate) - 1;
      dev_wr(A_CTRL, rate << 1);
      for (int k = 0; k < 8; k++) begin
        s = {$random(seed)} % 16;
        os = {$random(seed)} % 16;
        a = os * 32 + {$random(seed)} % 32;
        if (k < 4) begin
          dev_wr(A_IDLY + s, (k[0] ? 1 + {$random(seed)} % mk : 0) << 3 | {$random(seed)} % 8);
          dev_wr(A_ODLY + os, (k[1] ? 1 + {$random(seed)} % mk : 0) << 5 | {$random(seed)} % 32);
          dev_wr(a, s << 8 | ({$random(seed)} % (mk + 1)) << 1);
        end else dev_wr(a, ({$random(seed)} % 256) << 3 | (k - 4) << 1 | 1);
        look(a);
      end
    end
    // Controller fill job for every pattern
    for (p = 0; p < 8; p++) begin
      busy_n = 0;
      axi_wr(H_JOB, p << 2 | rate << 5 | 1, r);
      wait_idle();
      chk("fill time", busy_n > 0 && busy_n <= 16'h1388, 1);
      foreach (cm[i]) cm[i] = p;
      foreach (probe[i]) begin
        dev_rd(probe[i], v);
        chk("fill entry", v, p);
      end
    end
    axi_wr(H_JOB, 2, r);
    wait_idle();
    dev_rd(A_MODE, v);
    chk("abort job", v & 1, 0);
    // Abort by enable, by start, full run; entry writes refused
    for (int kd = 0; kd < 3; kd++) begin
      p = 2 * kd + 2;
      dev_wr(A_MODE, p << 1);
      dev_wr(A_CTRL, rate << 1 | 1);
      dev_wr(A_MODE, p << 1 | 1);
      dev_wr(0, 12'h0ABC);
      cm[0] = p;
      if (kd == 0) begin
        dev_wr(A_CTRL, rate << 1);
        dev_rd(A_MODE, v);
        chk("start held", v & 1, 1);
        dev_wr(A_MODE, p << 1);
      end else if (kd == 1) begin
        dev_wr(A_MODE, p << 1);
        dev_wr(A_CTRL, rate << 1);
      end else begin
        while (fill_busy !== 1'b0) @(posedge clk_in);
        dev_rd(A_MODE, v);
        chk("start cleared", v & 1, 0);
        dev_wr(A_CTRL, rate << 1);
        foreach (cm[i]) cm[i] = p;
      end
      chk("busy", fill_busy, 0);
      dev_rd(0, v);
      chk("first", v, cm[0]);
      dev_rd(511, v);
      chk("last", v, cm[511]);
    end
    // Start with enable low must not fill
    dev_wr(A_MODE, 5 << 1 | 1);
    chk("no fill", fill_busy, 0);
    dev_rd(0, v);
    chk("no fill entry", v, cm[0]);
    dev_wr(A_MODE, 0);
    give_verdict();
  end
endmodule : tdm_connection_memory_delay_tb_top
